/* File: mmx_defines.vh */
// shared constants for the move/multiply/reverse/extend/branch execute block
`ifndef MMX_DEFINES_VH
`define MMX_DEFINES_VH
// operation codes
`define MMX_OP_W 5
`define MMX_OP_NONE 5'h00
`define MMX_OP_COPY 5'h01
`define MMX_OP_COPY_FLAGSET 5'h02
`define MMX_OP_COPY_IMM 5'h03
`define MMX_OP_INVERT_COPY 5'h04
`define MMX_OP_MULTIPLY 5'h05
`define MMX_OP_WORD_REV 5'h06
`define MMX_OP_HALFWORD_PAIR_SWAP 5'h07
`define MMX_OP_SIGNED_HALF_SWAP 5'h08
`define MMX_OP_SIGN_EXTEND_BYTE 5'h09
`define MMX_OP_ZERO_EXTEND_BYTE 5'h0A
`define MMX_OP_SIGN_EXTEND_HALF 5'h0B
`define MMX_OP_ZERO_EXTEND_HALF 5'h0C
`define MMX_OP_BIT_TEST 5'h0D
`define MMX_OP_JUMP 5'h0E
`define MMX_OP_COND_JUMP 5'h0F
`define MMX_OP_LINKED_JUMP 5'h10
`define MMX_OP_INDIRECT_JUMP 5'h11
`define MMX_OP_LINKED_INDIRECT_JUMP 5'h12
// register numbers
`define MMX_REG_LINK 4'hE
`define MMX_REG_PC 4'hF
// branch offset limits in bytes
`define MMX_JUMP_MIN (-2048)
`define MMX_JUMP_MAX 2046
`define MMX_COND_MIN (-256)
`define MMX_COND_MAX 254
`define MMX_LINK_MIN (-16777216)
`define MMX_LINK_MAX 16777214
// instruction size added to form the following address
`define MMX_INSTR_BYTES 32'h00000002
`define MMX_LINK_INSTR_BYTES 32'h00000004
// flag reset value {n,z,c,v}
`define MMX_FLAGS_RST 4'h0
// thumb bit reset value
`define MMX_THUMB_RST 1'b1
`endif

/* File: mmx_byte_unit.v */
// byte reverse and extend result unit
`timescale 1ns/1ps
`include "mmx_defines.vh"
module mmx_byte_unit (
   // operation and operand
   input wire [`MMX_OP_W-1:0] op_i,
   input wire [31:0] src_i,
   // result
   output reg [31:0] res_o,
   output reg hit_o
);
   always @* begin
      hit_o = 1'b1;
      case (op_i)
         `MMX_OP_WORD_REV: res_o = {src_i[7:0], src_i[15:8], src_i[23:16], src_i[31:24]};
         `MMX_OP_HALFWORD_PAIR_SWAP: res_o = {src_i[23:16], src_i[31:24], src_i[7:0], src_i[15:8]};
         `MMX_OP_SIGNED_HALF_SWAP: res_o = {{16{src_i[7]}}, src_i[7:0], src_i[15:8]};
         `MMX_OP_SIGN_EXTEND_BYTE: res_o = {{24{src_i[7]}}, src_i[7:0]};
         `MMX_OP_ZERO_EXTEND_BYTE: res_o = {24'h000000, src_i[7:0]};
         `MMX_OP_SIGN_EXTEND_HALF: res_o = {{16{src_i[15]}}, src_i[15:0]};
         `MMX_OP_ZERO_EXTEND_HALF: res_o = {16'h0000, src_i[15:0]};
         default: begin
            res_o = 32'h00000000;
            hit_o = 1'b0;
         end
      endcase
   end
endmodule // mmx_byte_unit

/* File: mmx_cond_eval.v */
// condition code evaluation against the current flags
`timescale 1ns/1ps
module mmx_cond_eval (
   // condition and flags
   input wire [3:0] cond_i,
   input wire [3:0] flags_i,
   // outcome
   output reg pass_o
);
   wire n;
   wire z;
   wire c;
   wire v;
   reg base;
   assign n = flags_i[3];
   assign z = flags_i[2];
   assign c = flags_i[1];
   assign v = flags_i[0];
   // pairs of codes share a test; the low bit inverts it, code 4'hF is treated as always
   always @* begin
      case (cond_i[3:1])
         3'h0: base = z;
         3'h1: base = c;
         3'h2: base = n;
         3'h3: base = v;
         3'h4: base = c & ~z;
         3'h5: base = (n == v);
         3'h6: base = ~z & (n == v);
         default: base = 1'b1;
      endcase
      if (cond_i[0] && cond_i != 4'hF) begin
         pass_o = ~base;
      end else begin
         pass_o = base;
      end
   end
endmodule // mmx_cond_eval

/* File: mmx_exec.v */
// execute stage for move, multiply, byte reverse, extend, bit test and branch operations
`timescale 1ns/1ps
`include "mmx_defines.vh"
module mmx_exec (
   // clock and reset
   input wire mclk_i,
   input wire rst_i,
   // decoded operation
   input wire issue_i,
   input wire [`MMX_OP_W-1:0] op_i,
   input wire [3:0] dest_reg_i,
   input wire [31:0] first_src_reg_i,
   input wire [31:0] second_src_reg_i,
   input wire [7:0] imm8_i,
   input wire [3:0] cond_i,
   input wire [31:0] offset_i,
   input wire [31:0] pc_i,
   // register file write
   output reg wr_en_o,
   output reg [3:0] wr_reg_o,
   output reg [31:0] wr_data_o,
   // link register write
   output reg link_wr_o,
   output reg [31:0] link_register_o,
   // branch
   output reg branch_o,
   output reg [31:0] branch_target_o,
   // status
   output reg [3:0] flags_o,
   output reg thumb_o,
   output reg hard_fault_exception_o,
   output reg offset_error_o
);
   // registered state behind the outputs
   reg [3:0] flags_ff;
   reg thumb_ff;
   reg wr_en_ff;
   reg [3:0] wr_reg_ff;
   reg [31:0] wr_data_ff;
   reg link_wr_ff;
   reg [31:0] link_ff;
   reg branch_ff;
   reg [31:0] target_ff;
   reg fault_ff;
   reg off_err_ff;
   // next-state values
   reg [3:0] nxt_flags;
   reg nxt_thumb;
   reg nxt_wr_en;
   reg [31:0] nxt_wr_data;
   reg nxt_link_wr;
   reg [31:0] nxt_link;
   reg nxt_branch;
   reg [31:0] nxt_target;
   reg nxt_fault;
   reg nxt_off_err;
   reg set_nz;
   reg [31:0] nz_val;
   wire [31:0] byte_res;
   wire byte_hit;
   wire cond_pass;
   wire [63:0] product;
   wire [31:0] rel_target;
   wire signed [31:0] off_s;
   wire jump_in_range;
   wire cond_in_range;
   wire link_in_range;
   // the low half of the product is the same for signed and unsigned operands
   assign product = first_src_reg_i * second_src_reg_i;
   assign rel_target = pc_i + offset_i;
   assign off_s = offset_i;
   // offsets are halfword aligned; odd offsets are outside the encodable set
   assign jump_in_range = (off_s >= `MMX_JUMP_MIN) && (off_s <= `MMX_JUMP_MAX) && !offset_i[0];
   assign cond_in_range = (off_s >= `MMX_COND_MIN) && (off_s <= `MMX_COND_MAX) && !offset_i[0];
   assign link_in_range = (off_s >= `MMX_LINK_MIN) && (off_s <= `MMX_LINK_MAX) && !offset_i[0];
   // byte reverse and extend results share one unit
   mmx_byte_unit u_byte (
      .op_i(op_i),
      .src_i(second_src_reg_i),
      .res_o(byte_res),
      .hit_o(byte_hit)
   );
   // the condition sees the flags as they stand before this issue updates them
   mmx_cond_eval u_cond (
      .cond_i(cond_i),
      .flags_i(flags_ff),
      .pass_o(cond_pass)
   );
   // register write and flag result of the issued operation
   always @* begin
      nxt_flags = flags_ff;
      nxt_wr_en = 1'b0;
      nxt_wr_data = 32'h00000000;
      set_nz = 1'b0;
      nz_val = 32'h00000000;
      if (issue_i) begin
         case (op_i)
            `MMX_OP_COPY: begin
               // a copy into the program counter is a jump, not a register write
               if (dest_reg_i != `MMX_REG_PC) begin
                  nxt_wr_en = 1'b1;
                  nxt_wr_data = second_src_reg_i;
               end
            end
            `MMX_OP_COPY_FLAGSET: begin
               nxt_wr_en = 1'b1;
               nxt_wr_data = second_src_reg_i;
               set_nz = 1'b1;
               nz_val = second_src_reg_i;
            end
            `MMX_OP_COPY_IMM: begin
               nxt_wr_en = 1'b1;
               nxt_wr_data = {24'h000000, imm8_i};
               set_nz = 1'b1;
               nz_val = {24'h000000, imm8_i};
            end
            `MMX_OP_INVERT_COPY: begin
               nxt_wr_en = 1'b1;
               nxt_wr_data = ~second_src_reg_i;
               set_nz = 1'b1;
               nz_val = ~second_src_reg_i;
            end
            `MMX_OP_MULTIPLY: begin
               // destination is taken as given; software keeps it equal to the second source
               nxt_wr_en = 1'b1;
               nxt_wr_data = product[31:0];
               set_nz = 1'b1;
               nz_val = product[31:0];
            end
            `MMX_OP_BIT_TEST: begin
               set_nz = 1'b1;
               nz_val = first_src_reg_i & second_src_reg_i;
            end
            default: begin
               if (byte_hit) begin
                  nxt_wr_en = 1'b1;
                  nxt_wr_data = byte_res;
               end
            end
         endcase
         // c and v are never produced here, so they always carry over
         if (set_nz) begin
            nxt_flags = {nz_val[31], (nz_val == 32'h00000000), flags_ff[1:0]};
         end
      end
   end
   // control flow: jumps, link writes, thumb bit and faults
   always @* begin
      nxt_thumb = thumb_ff;
      nxt_link_wr = 1'b0;
      nxt_link = link_ff;
      nxt_branch = 1'b0;
      nxt_target = target_ff;
      nxt_fault = 1'b0;
      nxt_off_err = 1'b0;
      if (issue_i) begin
         case (op_i)
            `MMX_OP_COPY: begin
               // the thumb bit is left as it is on a copy into the program counter
               if (dest_reg_i == `MMX_REG_PC) begin
                  nxt_branch = 1'b1;
                  nxt_target = {second_src_reg_i[31:1], 1'b0};
               end
            end
            `MMX_OP_JUMP: begin
               if (jump_in_range) begin
                  nxt_branch = 1'b1;
                  nxt_target = rel_target;
               end else begin
                  nxt_off_err = 1'b1;
               end
            end
            `MMX_OP_COND_JUMP: begin
               if (!cond_in_range) begin
                  nxt_off_err = 1'b1;
               end else if (cond_pass) begin
                  nxt_branch = 1'b1;
                  nxt_target = rel_target;
               end
            end
            `MMX_OP_LINKED_JUMP: begin
               if (link_in_range) begin
                  nxt_branch = 1'b1;
                  nxt_target = rel_target;
                  nxt_link_wr = 1'b1;
                  // the linked form is a two-halfword instruction
                  nxt_link = (pc_i + `MMX_LINK_INSTR_BYTES) | 32'h00000001;
               end else begin
                  nxt_off_err = 1'b1;
               end
            end
            `MMX_OP_INDIRECT_JUMP, `MMX_OP_LINKED_INDIRECT_JUMP: begin
               nxt_thumb = second_src_reg_i[0];
               if (!second_src_reg_i[0]) begin
                  // no branch or link write on a faulting target
                  nxt_fault = 1'b1;
               end else begin
                  nxt_branch = 1'b1;
                  nxt_target = {second_src_reg_i[31:1], 1'b0};
                  if (op_i == `MMX_OP_LINKED_INDIRECT_JUMP) begin
                     nxt_link_wr = 1'b1;
                     nxt_link = (pc_i + `MMX_INSTR_BYTES) | 32'h00000001;
                  end
               end
            end
            default: begin
               // all other operations leave the control flow alone
            end
         endcase
      end
   end
   // condition flags and thumb bit
   always @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         flags_ff <= `MMX_FLAGS_RST;
         thumb_ff <= `MMX_THUMB_RST;
      end else begin
         flags_ff <= nxt_flags;
         thumb_ff <= nxt_thumb;
      end
   end
   // register write port; the destination number is sampled every cycle
   always @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         wr_en_ff <= 1'b0;
         wr_reg_ff <= 4'h0;
         wr_data_ff <= 32'h00000000;
      end else begin
         wr_en_ff <= nxt_wr_en;
         wr_reg_ff <= dest_reg_i;
         wr_data_ff <= nxt_wr_data;
      end
   end
   // link write pulse; the value holds after the pulse
   always @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         link_wr_ff <= 1'b0;
         link_ff <= 32'h00000000;
      end else begin
         link_wr_ff <= nxt_link_wr;
         link_ff <= nxt_link;
      end
   end
   // jump pulse; the target holds after the pulse
   always @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         branch_ff <= 1'b0;
         target_ff <= 32'h00000000;
      end else begin
         branch_ff <= nxt_branch;
         target_ff <= nxt_target;
      end
   end
   // one-cycle exception pulses
   always @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         fault_ff <= 1'b0;
         off_err_ff <= 1'b0;
      end else begin
         fault_ff <= nxt_fault;
         off_err_ff <= nxt_off_err;
      end
   end
   // outputs mirror the flops so every port is registered
   always @* begin
      wr_en_o = wr_en_ff;
      wr_reg_o = wr_reg_ff;
      wr_data_o = wr_data_ff;
      link_wr_o = link_wr_ff;
      link_register_o = link_ff;
      branch_o = branch_ff;
      branch_target_o = target_ff;
      flags_o = flags_ff;
      thumb_o = thumb_ff;
      hard_fault_exception_o = fault_ff;
      offset_error_o = off_err_ff;
   end
endmodule // mmx_exec

/* File: mmx_exec_properties.sv */
// port assertions for the execute block
`timescale 1ns/1ps
`include "mmx_defines.vh"
module mmx_exec_properties (
   // clock and reset
   input wire mclk_i,
   input wire rst_i,
   // request
   input wire issue_i,
   input wire [`MMX_OP_W-1:0] op_i,
   input wire [3:0] dest_reg_i,
   input wire [31:0] first_src_reg_i,
   input wire [31:0] second_src_reg_i,
   input wire [31:0] pc_i,
   // results
   input wire wr_en_o,
   input wire [31:0] wr_data_o,
   input wire link_wr_o,
   input wire [31:0] link_register_o,
   input wire branch_o,
   input wire [3:0] flags_o,
   input wire hard_fault_exception_o
);
   default clocking @(posedge mclk_i);
   endclocking
   default disable iff (rst_i);
   property p_copy;
      issue_i && op_i == `MMX_OP_COPY && dest_reg_i != `MMX_REG_PC |=>
         wr_en_o && wr_data_o == $past(second_src_reg_i) && $stable(flags_o);
   endproperty
   a_copy: assert property (p_copy) else $error("copy wrong");
   property p_inv;
      issue_i && op_i == `MMX_OP_INVERT_COPY |=> wr_data_o == ~$past(second_src_reg_i)
         && flags_o == {wr_data_o[31], wr_data_o == 32'h0, $past(flags_o[1:0])};
   endproperty
   a_inv: assert property (p_inv) else $error("invert wrong");
   property p_mul;
      issue_i && op_i == `MMX_OP_MULTIPLY |=>
         wr_en_o && wr_data_o == $past(first_src_reg_i * second_src_reg_i);
   endproperty
   a_mul: assert property (p_mul) else $error("product wrong");
   property p_mulf;
      issue_i && op_i == `MMX_OP_MULTIPLY |=>
         flags_o == {wr_data_o[31], wr_data_o == 32'h0, $past(flags_o[1:0])};
   endproperty
   a_mulf: assert property (p_mulf) else $error("product flags wrong");
   property p_ext;
      issue_i && op_i >= `MMX_OP_SIGN_EXTEND_BYTE && op_i <= `MMX_OP_ZERO_EXTEND_HALF
         |=> wr_en_o && $stable(flags_o);
   endproperty
   a_ext: assert property (p_ext) else $error("extend touched flags");
   property p_tst;
      issue_i && op_i == `MMX_OP_BIT_TEST |=> !wr_en_o && flags_o[3:2] ==
         {$past(first_src_reg_i[31] & second_src_reg_i[31]),
          $past((first_src_reg_i & second_src_reg_i) == 32'h0)};
   endproperty
   a_tst: assert property (p_tst) else $error("bit test wrong");
   property p_fault;
      issue_i && !second_src_reg_i[0] && (op_i == `MMX_OP_INDIRECT_JUMP
         || op_i == `MMX_OP_LINKED_INDIRECT_JUMP) |=>
         hard_fault_exception_o && !branch_o && !link_wr_o;
   endproperty
   a_fault: assert property (p_fault) else $error("no fault");
   property p_link;
      issue_i && op_i == `MMX_OP_LINKED_INDIRECT_JUMP && second_src_reg_i[0] |=>
         link_wr_o && link_register_o == ($past(pc_i) + 32'h2 | 32'h1);
   endproperty
   a_link: assert property (p_link) else $error("link wrong");
endmodule // mmx_exec_properties

/* File: mmx_regfile_model.sv */
// register file on the far side: takes the block's write pulses
`timescale 1ns/1ps
module mmx_regfile_model (
   // clock and writes
   input wire mclk_i,
   input wire wr_en_i,
   input wire [3:0] wr_reg_i,
   input wire [31:0] wr_data_i,
   input wire link_wr_i,
   input wire [31:0] link_i,
   // read port
   input wire [3:0] rd_reg_i,
   output wire [31:0] rd_data_o
);
   reg [31:0] regs_ff [0:15];
   always @(posedge mclk_i) begin
      if (wr_en_i)
         regs_ff[wr_reg_i] <= wr_data_i;
      if (link_wr_i)
         regs_ff[4'hE] <= link_i;
   end
   assign rd_data_o = regs_ff[rd_reg_i];
endmodule // mmx_regfile_model

/* File: tb_top.sv */
// self-checking bench for the execute block
`timescale 1ns/1ps
`include "mmx_defines.vh"
module tb_top;
   reg mclk_i = 0;
   reg rst_i = 1;
   reg issue_i = 0;
   reg [4:0] op_i = 0;
   reg [3:0] dest_reg_i = 0;
   reg [3:0] cond_i = 0;
   reg [7:0] imm8_i = 0;
   reg [31:0] first_src_reg_i = 0, second_src_reg_i = 0, offset_i = 0, pc_i = 0;
   wire wr_en_o, link_wr_o, branch_o, thumb_o, hard_fault_exception_o, offset_error_o;
   wire [3:0] wr_reg_o, flags_o;
   wire [31:0] wr_data_o, link_register_o, branch_target_o, rf_link;
   reg [223:0] bexp = {32'h0000B380, 32'hFFFFB380, 32'h00000080, 32'hFFFFFF80,
                       32'hFFFF80B3, 32'h221180B3, 32'h80B32211};
   integer n_mismatch = 0, total_checks = 0, i;
   always #2 mclk_i = ~mclk_i;
   mmx_exec i_mmx_exec (
      .mclk_i(mclk_i),
      .rst_i(rst_i),
      .issue_i(issue_i),
      .op_i(op_i),
      .dest_reg_i(dest_reg_i),
      .first_src_reg_i(first_src_reg_i),
      .second_src_reg_i(second_src_reg_i),
      .imm8_i(imm8_i),
      .cond_i(cond_i),
      .offset_i(offset_i),
      .pc_i(pc_i),
      .wr_en_o(wr_en_o),
      .wr_reg_o(wr_reg_o),
      .wr_data_o(wr_data_o),
      .link_wr_o(link_wr_o),
      .link_register_o(link_register_o),
      .branch_o(branch_o),
      .branch_target_o(branch_target_o),
      .flags_o(flags_o),
      .thumb_o(thumb_o),
      .hard_fault_exception_o(hard_fault_exception_o),
      .offset_error_o(offset_error_o)
   );
   mmx_regfile_model i_mmx_regfile_model (.mclk_i(mclk_i), .wr_en_i(wr_en_o),
      .wr_reg_i(wr_reg_o), .wr_data_i(wr_data_o), .link_wr_i(link_wr_o),
      .link_i(link_register_o), .rd_reg_i(4'hE), .rd_data_o(rf_link));
   task chk(input string nm, input [31:0] exp, input [31:0] got);
      begin
         total_checks = total_checks + 1;
         if (got !== exp) begin
            n_mismatch = n_mismatch + 1;
            $display("ERROR %0s expected %h seen %h", nm, exp, got);
         end
      end
   endtask
   // one-cycle issue; results of the issue edge are settled at the next falling edge
   task run(input [4:0] op, input [3:0] rd, input [31:0] a, input [31:0] b, input [31:0] off);
      begin
         @(negedge mclk_i);
         issue_i = 1;
         op_i = op;
         dest_reg_i = rd;
         first_src_reg_i = a;
         second_src_reg_i = b;
         offset_i = off;
         @(negedge mclk_i);
         issue_i = 0;
      end
   endtask
   task rng(input [4:0] op, input [31:0] off, input ok);
      begin
         run(op, 4'h0, 32'h0, 32'h0, off);
         chk("branch", ok, branch_o);
         chk("off_err", !ok, offset_error_o);
      end
   endtask
   task stop_test;
      begin
         if (n_mismatch == 0 && total_checks > 0)
            $display("Test passed");
         else
            $display("Test failed");
         $finish;
      end
   endtask
   initial begin
      #100000;
      n_mismatch = n_mismatch + 1;
      stop_test;
   end
   initial begin
      repeat (20) @(negedge mclk_i);
      rst_i = 0;
      run(`MMX_OP_COPY, 4'h2, 32'h0, 32'hA5A51234, 32'h0);
      chk("copy", 32'hA5A51234, wr_data_o);
      chk("wr_reg", 32'h2, wr_reg_o);
      chk("flags", 4'h0, flags_o);
      imm8_i = 8'hFF;
      run(`MMX_OP_COPY_IMM, 4'h1, 32'h0, 32'h0, 32'h0);
      chk("imm", 32'hFF, wr_data_o);
      imm8_i = 8'h0;
      run(`MMX_OP_COPY_IMM, 4'h1, 32'h0, 32'h0, 32'h0);
      chk("flags", 4'h4, flags_o);
      run(`MMX_OP_COPY_FLAGSET, 4'h6, 32'h0, 32'h7FFFFFFF, 32'h0);
      chk("copy_s", 32'h7FFFFFFF, wr_data_o);
      chk("flags", 4'h0, flags_o);
      run(`MMX_OP_INVERT_COPY, 4'h3, 32'h0, 32'h0, 32'h0);
      chk("inv", 32'hFFFFFFFF, wr_data_o);
      chk("flags", 4'h8, flags_o);
      run(`MMX_OP_MULTIPLY, 4'h3, 32'h10000, 32'h10000, 32'h0);
      chk("mul", 32'h0, wr_data_o);
      chk("flags", 4'h4, flags_o);
      for (i = 0; i < 7; i = i + 1) begin
         run(`MMX_OP_WORD_REV + i[4:0], 4'h4, 32'h0, 32'h1122B380, 32'h0);
         chk("byte", bexp[i*32 +: 32], wr_data_o);
         chk("flags", 4'h4, flags_o);
      end
      run(`MMX_OP_BIT_TEST, 4'h5, 32'h80000000, 32'h80000001, 32'h0);
      chk("flags", 4'h8, flags_o);
      run(`MMX_OP_BIT_TEST, 4'h5, 32'hF0, 32'h0F, 32'h0);
      chk("flags", 4'h4, flags_o);
      chk("wr_en", 32'h0, wr_en_o);
      pc_i = 32'h1000;
      for (i = 0; i < 16; i = i + 1) begin
         cond_i = i[3:0];
         run(`MMX_OP_COND_JUMP, 4'h0, 32'h0, 32'h0, 32'hFFFFFF00);
         chk("cond", 16'hE6A9 >> i & 1, branch_o);
      end
      chk("target", 32'hF00, branch_target_o);
      cond_i = 4'hE;
      rng(`MMX_OP_JUMP, 32'h7FE, 1'h1);
      rng(`MMX_OP_JUMP, 32'h800, 1'h0);
      rng(`MMX_OP_JUMP, 32'hFFFFF800, 1'h1);
      rng(`MMX_OP_COND_JUMP, 32'hFE, 1'h1);
      rng(`MMX_OP_COND_JUMP, 32'h100, 1'h0);
      rng(`MMX_OP_LINKED_JUMP, 32'h01000000, 1'h0);
      rng(`MMX_OP_LINKED_JUMP, 32'hFF000000, 1'h1);
      chk("link", 32'h1005, link_register_o);
      pc_i = 32'h100;
      run(`MMX_OP_LINKED_INDIRECT_JUMP, 4'h0, 32'h0, 32'h4001, 32'h0);
      chk("target", 32'h4000, branch_target_o);
      chk("link", 32'h103, link_register_o);
      chk("link_wr", 32'h1, link_wr_o);
      run(`MMX_OP_INDIRECT_JUMP, 4'h0, 32'h0, 32'h5000, 32'h0);
      chk("fault", 32'h1, hard_fault_exception_o);
      chk("branch", 32'h0, branch_o);
      chk("thumb", 32'h0, thumb_o);
      chk("rf_link", 32'h103, rf_link);
      run(`MMX_OP_COPY, `MMX_REG_PC, 32'h0, 32'h2001, 32'h0);
      chk("target", 32'h2000, branch_target_o);
      chk("branch", 32'h1, branch_o);
      chk("wr_en", 32'h0, wr_en_o);
      chk("thumb", 32'h0, thumb_o);
      run(`MMX_OP_INDIRECT_JUMP, 4'h0, 32'h0, 32'h3001, 32'h0);
      chk("thumb", 32'h1, thumb_o);
      // second reset in mid-run: flags, target and link must read zero by the next falling edge
      rst_i = 1;
      @(negedge mclk_i);
      chk("flags", 4'h0, flags_o);
      chk("target", 32'h0, branch_target_o);
      chk("link", 32'h0, link_register_o);
      rst_i = 0;
      run(`MMX_OP_COPY, 4'h7, 32'h0, 32'h5A, 32'h0);
      chk("copy", 32'h5A, wr_data_o);
      stop_test;
   end
endmodule // tb_top
bind mmx_exec mmx_exec_properties i_mmx_exec_properties (.mclk_i, .rst_i, .issue_i,
   .op_i, .dest_reg_i, .first_src_reg_i, .second_src_reg_i, .pc_i, .wr_en_o, .wr_data_o,
   .link_wr_o, .link_register_o, .branch_o, .flags_o, .hard_fault_exception_o);
